// ---- logic/dtf_pkg.sv ----
package dtf_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_HIGH = 8'h04;
    localparam logic [7:0] OFF_LOW = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_ELAPSED = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************
    // Field layout
    // ********************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RETAIN_BIT = 2;
    localparam int CTRL_INV_TRG_BIT = 3;
    localparam int CTRL_INV_RST_BIT = 4;
    localparam int CTRL_USE_REF_BIT = 5;
    localparam int CTRL_TB_HIGH_LSB = 6;
    localparam int CTRL_TB_LOW_LSB = 8;
    localparam int CTRL_SRC_LSB = 10;
    localparam int CTRL_W = 14;
    localparam int DELAY_W = 14;
    localparam int ELAPSED_W = 26;
    localparam int SRC_SEL_W = 4;
    localparam int VAL_W = 32;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [13:0] CTRL_RST = 14'h0000;
    localparam logic [13:0] HIGH_RST = 14'h0064;
    localparam logic [13:0] LOW_RST = 14'h0064;

    // ********************************
    // Modes and timebases
    // ********************************
    localparam logic [1:0] MODE_ON = 2'h0;
    localparam logic [1:0] MODE_OFF = 2'h1;
    localparam logic [1:0] MODE_ONOFF = 2'h2;
    localparam logic [1:0] TB_FINE = 2'h0;
    localparam logic [1:0] TB_MID = 2'h1;
    localparam logic [1:0] TB_COARSE = 2'h2;

    // ********************************
    // Timing
    // ********************************
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [31:0] FIX_MAX_S = 32'h0000270f;
    localparam logic [31:0] FIX_MAX_MH = 32'h0000176f;
    localparam logic [31:0] REF_MAX_MS = 32'h00018696;
    localparam logic [31:0] REF_MAX_SM = 32'h0000176f;
    localparam logic [31:0] MS_PER_TICK = 32'h0000000a;
    localparam logic [31:0] TICKS_PER_S = 32'h00000064;
    localparam logic [31:0] TICKS_PER_MIN = 32'h00001770;

endpackage

// ---- logic/dtf_delay_conv.sv ----
`timescale 1ns/100ps
module dtf_delay_conv (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic use_ref_i,
    input wire logic [1:0] timebase_i,
    input wire logic [13:0] fixed_i,
    input wire logic signed [31:0] ref_i,
    output logic [25:0] ticks_o
);

    logic [31:0] raw;
    logic [31:0] lim;
    logic [31:0] prod;

    // Smaller of value and limit
    function automatic logic [31:0] dtf_clamp(input logic [31:0] v, input logic [31:0] m);
        dtf_clamp = (v > m) ? m : v;
    endfunction

    // ********************************
    // Conversion to 10 ms ticks
    // ********************************
    always_comb begin
        raw = 32'h0;
        lim = 32'h0;
        prod = 32'h0;
        if (use_ref_i) begin
            raw = ref_i[31] ? 32'h0 : $unsigned(ref_i);
            case (timebase_i)
                dtf_pkg::TB_FINE: begin
                    lim = dtf_clamp(raw, dtf_pkg::REF_MAX_MS);
                    prod = lim / dtf_pkg::MS_PER_TICK;
                end
                dtf_pkg::TB_MID: begin
                    lim = dtf_clamp(raw, dtf_pkg::REF_MAX_SM);
                    prod = lim * dtf_pkg::TICKS_PER_S;
                end
                default: begin
                    lim = dtf_clamp(raw, dtf_pkg::REF_MAX_SM);
                    prod = lim * dtf_pkg::TICKS_PER_MIN;
                end
            endcase
        end else begin
            raw = {18'h0, fixed_i};
            case (timebase_i)
                dtf_pkg::TB_FINE: begin
                    prod = dtf_clamp(raw, dtf_pkg::FIX_MAX_S);
                end
                dtf_pkg::TB_MID: begin
                    lim = dtf_clamp(raw, dtf_pkg::FIX_MAX_MH);
                    prod = lim * dtf_pkg::TICKS_PER_S;
                end
                default: begin
                    lim = dtf_clamp(raw, dtf_pkg::FIX_MAX_MH);
                    prod = lim * dtf_pkg::TICKS_PER_MIN;
                end
            endcase
        end
    end

    // Registered delay in ticks
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ticks_o <= 26'h0;
        end else begin
            ticks_o <= prod[25:0];
        end
    end

endmodule

// ---- logic/dtf_delay_timer.sv ----
`timescale 1ns/100ps
module dtf_delay_timer #(
    parameter int unsigned TICK_CYCLES = dtf_pkg::TICK_CYCLES,
    parameter int NSRC = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic trigger_i,
    input wire logic block_reset_i,
    input wire logic power_loss_i,
    input wire logic [NSRC*32-1:0] src_values_i,
    output logic timer_out_o
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT_ON = 4'b0010,
        ST_ON = 4'b0100,
        ST_WAIT_OFF = 4'b1000
    } dtf_state_t;

    // ********************************
    // Declarations
    // ********************************
    logic [13:0] ctrl_reg;
    logic [13:0] high_reg;
    logic [13:0] low_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic trg_prev_reg;
    logic signed [31:0] ref_val_reg;
    dtf_state_t state_reg;
    dtf_state_t state_next;
    logic [25:0] elapsed_reg;
    logic [25:0] elapsed_next;
    logic out_reg;
    logic [25:0] high_ticks;
    logic [25:0] low_ticks;
    logic [25:0] off_ticks;
    logic [1:0] mode;
    logic retain;
    logic trg;
    logic blk_rst;
    logic rise;
    logic clr_now;
    logic wr_fire;
    logic [31:0] wr_merged;
    logic [dtf_pkg::SRC_SEL_W-1:0] src_sel;

    assign mode = ctrl_reg[dtf_pkg::CTRL_MODE_LSB +: 2];
    assign retain = ctrl_reg[dtf_pkg::CTRL_RETAIN_BIT];
    assign src_sel = ctrl_reg[dtf_pkg::CTRL_SRC_LSB +: dtf_pkg::SRC_SEL_W];

    // Input inversion and edge detection
    assign trg = trigger_i ^ ctrl_reg[dtf_pkg::CTRL_INV_TRG_BIT];
    assign blk_rst = block_reset_i ^ ctrl_reg[dtf_pkg::CTRL_INV_RST_BIT];
    assign rise = trg & ~trg_prev_reg;
    assign clr_now = (power_loss_i & ~retain) | ((mode == dtf_pkg::MODE_OFF) & blk_rst);
    assign off_ticks = (mode == dtf_pkg::MODE_OFF) ? high_ticks : low_ticks;

    // Outputs straight from flip-flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign timer_out_o = out_reg;

    // ********************************
    // Register bus
    // ********************************

    // Register read mux, unmapped reads as zero
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        reg_read = 32'h0;
        if (w == dtf_pkg::OFF_CTRL) reg_read = {18'h0, ctrl_reg};
        if (w == dtf_pkg::OFF_HIGH) reg_read = {18'h0, high_reg};
        if (w == dtf_pkg::OFF_LOW) reg_read = {18'h0, low_reg};
        if (w == dtf_pkg::OFF_STATUS) reg_read = {27'h0, state_reg, out_reg};
        if (w == dtf_pkg::OFF_ELAPSED) reg_read = {6'h0, elapsed_reg};
    endfunction

    // Address decode of mapped offsets
    function automatic logic reg_hit(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        reg_hit = (w <= dtf_pkg::OFF_ELAPSED);
    endfunction

    // Byte-lane merge of write data
    always_comb begin
        wr_merged = reg_read(aw_addr_reg);
        for (int b = 0; b < 4; b++) begin
            if (w_strb_reg[b]) wr_merged[b*8 +: 8] = w_data_reg[b*8 +: 8];
        end
    end

    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

    // Write channel: address and data in either order
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= dtf_pkg::RESP_OKAY;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (awready_reg && s_axi_awvalid_i) begin
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (wready_reg && s_axi_wvalid_i) begin
                wready_reg <= 1'b0;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= reg_hit(aw_addr_reg) ? dtf_pkg::RESP_OKAY : dtf_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Writable registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= dtf_pkg::CTRL_RST;
            high_reg <= dtf_pkg::HIGH_RST;
            low_reg <= dtf_pkg::LOW_RST;
        end else if (wr_fire) begin
            if ({aw_addr_reg[7:2], 2'b00} == dtf_pkg::OFF_CTRL) ctrl_reg <= wr_merged[13:0];
            if ({aw_addr_reg[7:2], 2'b00} == dtf_pkg::OFF_HIGH) high_reg <= wr_merged[13:0];
            if ({aw_addr_reg[7:2], 2'b00} == dtf_pkg::OFF_LOW) low_reg <= wr_merged[13:0];
        end
    end

    // Read channel
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= dtf_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
        end else if (arready_reg && s_axi_arvalid_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= reg_read(s_axi_araddr_i);
            rresp_reg <= reg_hit(s_axi_araddr_i) ? dtf_pkg::RESP_OKAY : dtf_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ********************************
    // Delay sources
    // ********************************

    // Referenced block value by block number
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ref_val_reg <= 32'sh0;
        end else if (int'(src_sel) < NSRC) begin
            ref_val_reg <= $signed(src_values_i[int'(src_sel)*32 +: 32]);
        end else begin
            ref_val_reg <= 32'sh0;
        end
    end

    // High delay may follow a block, low delay is fixed
    dtf_delay_conv u_conv_high (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .use_ref_i(ctrl_reg[dtf_pkg::CTRL_USE_REF_BIT]),
        .timebase_i(ctrl_reg[dtf_pkg::CTRL_TB_HIGH_LSB +: 2]),
        .fixed_i(high_reg),
        .ref_i(ref_val_reg),
        .ticks_o(high_ticks)
    );

    dtf_delay_conv u_conv_low (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .use_ref_i(1'b0),
        .timebase_i(ctrl_reg[dtf_pkg::CTRL_TB_LOW_LSB +: 2]),
        .fixed_i(low_reg),
        .ref_i(32'sh0),
        .ticks_o(low_ticks)
    );

    // ********************************
    // Timer core
    // ********************************

    // Common 10 ms tick divider
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // Next state and elapsed count
    always_comb begin
        state_next = state_reg;
        elapsed_next = elapsed_reg;
        if (clr_now) begin
            state_next = ST_IDLE;
            elapsed_next = 26'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (mode == dtf_pkg::MODE_OFF && trg) begin
                        state_next = ST_ON;
                    end else if (mode != dtf_pkg::MODE_OFF && rise) begin
                        state_next = ST_WAIT_ON;
                        elapsed_next = 26'h0;
                    end
                end
                ST_WAIT_ON: begin
                    if (!trg) begin
                        state_next = ST_IDLE;
                        elapsed_next = 26'h0;
                    end else if (mode == dtf_pkg::MODE_OFF || elapsed_reg >= high_ticks) begin
                        state_next = ST_ON;
                    end else if (tick_reg) begin
                        elapsed_next = elapsed_reg + 26'h1;
                    end
                end
                ST_ON: begin
                    elapsed_next = 26'h0;
                    if (!trg && mode == dtf_pkg::MODE_ON) begin
                        state_next = ST_IDLE;
                    end else if (!trg) begin
                        state_next = ST_WAIT_OFF;
                    end
                end
                ST_WAIT_OFF: begin
                    if (mode == dtf_pkg::MODE_ON) begin
                        state_next = ST_IDLE;
                        elapsed_next = 26'h0;
                    end else if (trg) begin
                        state_next = ST_ON;
                        elapsed_next = 26'h0;
                    end else if (elapsed_reg >= off_ticks) begin
                        state_next = ST_IDLE;
                        elapsed_next = 26'h0;
                    end else if (tick_reg) begin
                        elapsed_next = elapsed_reg + 26'h1;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    elapsed_next = 26'h0;
                end
            endcase
        end
    end

    // State, count and output registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            elapsed_reg <= 26'h0;
            out_reg <= 1'b0;
            trg_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            elapsed_reg <= elapsed_next;
            out_reg <= (state_next == ST_ON) || (state_next == ST_WAIT_OFF);
            trg_prev_reg <= trg;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_on_expire;
        (state_reg == ST_WAIT_ON && trg && elapsed_reg >= high_ticks && !clr_now) |=> out_reg;
    endproperty
    a_on_expire: assert property (p_on_expire) else $error("output not set at delay end");

    property p_on_abort;
        (state_reg == ST_WAIT_ON && !trg) |=> (state_reg == ST_IDLE && elapsed_reg == 26'h0);
    endproperty
    a_on_abort: assert property (p_on_abort) else $error("count not cleared on drop");

    property p_on_low;
        (mode == dtf_pkg::MODE_ON && !trg) |=> !out_reg;
    endproperty
    a_on_low: assert property (p_on_low) else $error("on-delay output high, trigger low");

    property p_loss;
        (power_loss_i && !retain) |=> (!out_reg && elapsed_reg == 26'h0);
    endproperty
    a_loss: assert property (p_loss) else $error("state kept after power loss");

    property p_off_set;
        (mode == dtf_pkg::MODE_OFF && trg && !clr_now) |=> out_reg;
    endproperty
    a_off_set: assert property (p_off_set) else $error("off-delay output not set at once");

    property p_off_start;
        (state_reg == ST_ON && !trg && mode != dtf_pkg::MODE_ON && !clr_now)
            |=> (state_reg == ST_WAIT_OFF && out_reg && elapsed_reg == 26'h0);
    endproperty
    a_off_start: assert property (p_off_start) else $error("fall did not start low delay");

    property p_off_end;
        (state_reg == ST_WAIT_OFF && !trg && elapsed_reg >= off_ticks && !clr_now) |=> !out_reg;
    endproperty
    a_off_end: assert property (p_off_end) else $error("output not cleared at delay end");

    property p_retrig;
        (state_reg == ST_WAIT_OFF && trg && mode != dtf_pkg::MODE_ON && !clr_now)
            |=> (state_reg == ST_ON && out_reg && elapsed_reg == 26'h0);
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger did not restart");

    property p_reset_in;
        (mode == dtf_pkg::MODE_OFF && blk_rst) |=> (!out_reg && elapsed_reg == 26'h0);
    endproperty
    a_reset_in: assert property (p_reset_in) else $error("reset input ignored");

    property p_tick;
        (tick_cnt_reg == 32'(TICK_CYCLES - 1)) |=> (tick_reg && tick_cnt_reg == 32'h0);
    endproperty
    a_tick: assert property (p_tick) else $error("tick missing at divider wrap");

    property p_level_no_start;
        (state_reg == ST_IDLE && mode != dtf_pkg::MODE_OFF && trg && trg_prev_reg && !clr_now)
            |=> state_reg == ST_IDLE;
    endproperty
    a_level_no_start: assert property (p_level_no_start) else $error("start without edge");

endmodule

// ---- verification/dtf_far_logic.sv ----
`timescale 1ns/100ps
module dtf_far_logic #(
    parameter int NSRC = 8,
    parameter int SEL = 2
) (
    input wire logic signed [31:0] value_i,
    output logic [NSRC*32-1:0] src_values_o
);
    // **********
    // Source blocks
    // **********
    // Chosen block shows the live value; the rest hold a long delay
    always_comb begin
        for (int k = 0; k < NSRC; k++) begin
            src_values_o[k*32+:32] = (k == SEL) ? value_i : 32'h00000fff;
        end
    end
endmodule

// ---- verification/tb_delay_timer_functions.sv ----
`timescale 1ns/100ps
module tb_delay_timer_functions;
    // **********
    // Bench signals
    // **********
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic trig = 1'b0, brst = 1'b0, pwr = 1'b0;
    logic signed [31:0] refv = 32'sh1e;
    logic awready, wready, bvalid, arready, rvalid, tout;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [255:0] srcv;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    // Clock at 250 MHz
    always #2 clock_i = ~clock_i;

    dtf_far_logic #(.NSRC(8), .SEL(2)) far (.value_i(refv), .src_values_o(srcv));

    dtf_delay_timer #(.TICK_CYCLES(4), .NSRC(8)) DUT (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .trigger_i(trig),
        .block_reset_i(brst), .power_loss_i(pwr), .src_values_i(srcv), .timer_out_o(tout)
    );

    // **********
    // Tasks
    // **********
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // Set the trigger, wait n edges, then compare the output
    task automatic step(input logic v, input int n, input logic e);
        trig <= v;
        repeat (n) @(posedge clock_i);
        chk("timer_out", {31'h0, e}, {31'h0, tout});
    endtask

    task automatic hold(input logic v, input int n);
        trig <= v;
        repeat (n) @(posedge clock_i);
    endtask

    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    // **********
    // Tests
    // **********
    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(dtf_pkg::OFF_CTRL, 32'h0, dtf_pkg::RESP_OKAY);
        rd(dtf_pkg::OFF_HIGH, 32'h64, dtf_pkg::RESP_OKAY);
        rd(dtf_pkg::OFF_LOW, 32'h64, dtf_pkg::RESP_OKAY);
        rd(8'h14, 32'h0, dtf_pkg::RESP_SLVERR);
        wr(8'h14, 32'h1, dtf_pkg::RESP_SLVERR);
        wr(dtf_pkg::OFF_HIGH, 32'h3, dtf_pkg::RESP_OKAY);
        wr(dtf_pkg::OFF_LOW, 32'h3, dtf_pkg::RESP_OKAY);
        $display("registers test ended");
        step(1'b1, 8, 1'b0);
        step(1'b1, 12, 1'b1);
        step(1'b0, 2, 1'b0);
        hold(1'b1, 8);
        hold(1'b0, 2);
        rd(dtf_pkg::OFF_ELAPSED, 32'h0, dtf_pkg::RESP_OKAY);
        step(1'b1, 8, 1'b0);
        step(1'b1, 12, 1'b1);
        step(1'b0, 2, 1'b0);
        $display("on-delay test ended");
        wr(dtf_pkg::OFF_CTRL, 32'h1, dtf_pkg::RESP_OKAY);
        step(1'b1, 2, 1'b1);
        rd(dtf_pkg::OFF_STATUS, 32'h9, dtf_pkg::RESP_OKAY);
        step(1'b0, 8, 1'b1);
        step(1'b0, 12, 1'b0);
        hold(1'b1, 2);
        hold(1'b0, 8);
        hold(1'b1, 2);
        step(1'b0, 8, 1'b1);
        step(1'b0, 12, 1'b0);
        hold(1'b1, 2);
        hold(1'b0, 2);
        brst <= 1'b1;
        step(1'b0, 2, 1'b0);
        brst <= 1'b0;
        rd(dtf_pkg::OFF_ELAPSED, 32'h0, dtf_pkg::RESP_OKAY);
        hold(1'b1, 2);
        hold(1'b0, 2);
        pwr <= 1'b1;
        hold(1'b0, 1);
        pwr <= 1'b0;
        step(1'b0, 2, 1'b0);
        wr(dtf_pkg::OFF_CTRL, 32'h5, dtf_pkg::RESP_OKAY);
        hold(1'b1, 2);
        hold(1'b0, 2);
        pwr <= 1'b1;
        hold(1'b0, 1);
        pwr <= 1'b0;
        step(1'b0, 2, 1'b1);
        step(1'b0, 16, 1'b0);
        brst <= 1'b1;
        wr(dtf_pkg::OFF_CTRL, 32'h19, dtf_pkg::RESP_OKAY);
        step(1'b0, 3, 1'b1);
        brst <= 1'b0;
        step(1'b1, 2, 1'b0);
        hold(1'b0, 2);
        $display("off-delay test ended");
        wr(dtf_pkg::OFF_CTRL, 32'h2, dtf_pkg::RESP_OKAY);
        step(1'b1, 8, 1'b0);
        step(1'b1, 12, 1'b1);
        hold(1'b0, 6);
        step(1'b1, 16, 1'b1);
        step(1'b0, 8, 1'b1);
        step(1'b0, 12, 1'b0);
        hold(1'b1, 6);
        step(1'b0, 16, 1'b0);
        $display("on/off-delay test ended");
        wr(dtf_pkg::OFF_CTRL, 32'h40, dtf_pkg::RESP_OKAY);
        wr(dtf_pkg::OFF_HIGH, 32'h1, dtf_pkg::RESP_OKAY);
        step(1'b1, 392, 1'b0);
        step(1'b1, 20, 1'b1);
        step(1'b0, 2, 1'b0);
        wr(dtf_pkg::OFF_CTRL, 32'h820, dtf_pkg::RESP_OKAY);
        step(1'b1, 8, 1'b0);
        step(1'b1, 12, 1'b1);
        step(1'b0, 2, 1'b0);
        refv <= -32'sh32;
        hold(1'b0, 3);
        step(1'b1, 4, 1'b1);
        // Power loss with a held trigger: no new start without an edge
        pwr <= 1'b1;
        hold(1'b1, 1);
        pwr <= 1'b0;
        step(1'b1, 4, 1'b0);
        $display("timebase test ended");
        wrap_up();
    end
endmodule
